/* File: rtl/nbh_top.sv */
// program sequencer with bad-block inhibit and axi4-lite registers
//
// Chosen here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module nbh_top (
	// clock, enable, reset
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	// axi4-lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output      logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output      logic        s_axi_wready,
	output      logic [1:0]  s_axi_bresp,
	output      logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output      logic        s_axi_arready,
	output      logic [31:0] s_axi_rdata,
	output      logic [1:0]  s_axi_rresp,
	output      logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// array side
	output      logic        arr_wr,
	output      logic [11:0] arr_col,
	output      logic [7:0]  arr_wdata,
	output      logic        arr_par_wr,
	output      logic [1:0]  arr_par_sec,
	output      logic [15:0] arr_par,
	output      logic        arr_prog,
	output      logic        arr_prot,
	output      logic        arr_erase,
	output      logic [10:0] arr_blk,
	output      logic [5:0]  arr_page,
	input  wire logic        arr_done,
	input  wire logic        arr_fail,
	input  wire logic        arr_rd_done,
	input  wire logic [3:0]  arr_flips,
	input  wire logic        fac_mark,
	input  wire logic [10:0] fac_blk,
	// interrupt
	output      logic        irq
);
	logic                rs1_q, rs_n;
	logic                aw_full_q, w_full_q, wr_go;
	logic [7:0]          waddr_q;
	logic [31:0]         wdata_q;
	logic                ecc_en_q, load_q, pfail_q, efail_q, prot_q;
	logic [10:0]         blk_q;
	logic [5:0]          page_q;
	logic [11:0]         col_q, cur_q;
	logic [1:0]          es_q, es;
	logic [3:0]          flip_q;
	logic [2:0]          ist_q, imask_q, iset;
	logic                cmd_go, dat_go, bad, clr;
	logic [7:0]          op;
	logic [1:0]          sec_q;
	logic [15:0]         par;
	logic                er_q;
	nbh_pkg::nbh_state_e st_q;

	// ****************
	// reset release
	// ****************
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rs1_q <= 1'b0;
			rs_n  <= 1'b0;
		end else begin
			rs1_q <= 1'b1;
			rs_n  <= rs1_q;
		end
	end
	// ****************
	// axi write channels
	// ****************
	assign wr_go = aw_full_q & w_full_q & ~s_axi_bvalid;
	always_ff @(posedge mclk or negedge rs_n) begin
		if (!rs_n) begin
			aw_full_q     <= 1'b0;
			s_axi_awready <= 1'b0;
			waddr_q       <= 8'h00;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_q     <= 1'b1;
				s_axi_awready <= 1'b0;
				waddr_q       <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_full_q     <= 1'b0;
				s_axi_awready <= 1'b1;
			end else begin
				s_axi_awready <= ~aw_full_q;
			end
		end
	end
	always_ff @(posedge mclk or negedge rs_n) begin
		if (!rs_n) begin
			w_full_q     <= 1'b0;
			s_axi_wready <= 1'b0;
			wdata_q      <= 32'h0000_0000;
		end else if (ce) begin
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_q     <= 1'b1;
				s_axi_wready <= 1'b0;
				wdata_q      <= s_axi_wdata & {{8{s_axi_wstrb[3]}},
					{8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}},
					{8{s_axi_wstrb[0]}}};
			end else if (wr_go) begin
				w_full_q     <= 1'b0;
				s_axi_wready <= 1'b1;
			end else begin
				s_axi_wready <= ~w_full_q;
			end
		end
	end
	always_ff @(posedge mclk or negedge rs_n) begin
		if (!rs_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= nbh_pkg::RESP_OK;
		end else if (ce) begin
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (waddr_q > nbh_pkg::A_IRQ_MASK ||
					waddr_q[1:0] != 2'h0) ? nbh_pkg::RESP_ERR
					: nbh_pkg::RESP_OK;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	// ****************
	// axi read channel
	// ****************
	always_ff @(posedge mclk or negedge rs_n) begin
		if (!rs_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= nbh_pkg::RESP_OK;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= nbh_pkg::RESP_OK;
				s_axi_rdata   <= 32'h0000_0000;
				case (s_axi_araddr)
				nbh_pkg::A_CTRL: s_axi_rdata[0] <= ecc_en_q;
				nbh_pkg::A_CMD: s_axi_rdata <= 32'h0000_0000;
				nbh_pkg::A_ROW: s_axi_rdata[16:0] <= {page_q, blk_q};
				nbh_pkg::A_COL: s_axi_rdata[11:0] <= col_q;
				nbh_pkg::A_DATA: s_axi_rdata[11:0] <= cur_q;
				nbh_pkg::A_STATUS: begin
					s_axi_rdata[11:0] <= {flip_q, 2'h0, es_q, efail_q,
						pfail_q, load_q, st_q != nbh_pkg::ST_IDLE};
				end
				nbh_pkg::A_IRQ_STAT: s_axi_rdata[2:0] <= ist_q;
				nbh_pkg::A_IRQ_MASK: s_axi_rdata[2:0] <= imask_q;
				default: s_axi_rresp <= nbh_pkg::RESP_ERR;
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end else begin
				s_axi_arready <= ~s_axi_rvalid;
			end
		end
	end
	// ****************
	// control registers
	// ****************
	assign cmd_go = wr_go && waddr_q == nbh_pkg::A_CMD;
	assign dat_go = wr_go && waddr_q == nbh_pkg::A_DATA && load_q;
	assign op     = wdata_q[7:0];
	always_ff @(posedge mclk or negedge rs_n) begin
		if (!rs_n) begin
			ecc_en_q <= 1'b1;
			blk_q    <= 11'h000;
			page_q   <= 6'h00;
			col_q    <= 12'h000;
			imask_q  <= 3'h0;
		end else if (ce && wr_go) begin
			case (waddr_q)
			nbh_pkg::A_CTRL: ecc_en_q <= wdata_q[0];
			nbh_pkg::A_ROW: {page_q, blk_q} <= wdata_q[16:0];
			nbh_pkg::A_COL: col_q <= wdata_q[11:0];
			nbh_pkg::A_IRQ_MASK: imask_q <= wdata_q[2:0];
			default: ;
			endcase
		end
	end
	// ****************
	// load pointer
	// ****************
	assign clr = cmd_go && op == nbh_pkg::OP_LOAD &&
		st_q == nbh_pkg::ST_IDLE;
	always_ff @(posedge mclk or negedge rs_n) begin
		if (!rs_n) begin
			load_q <= 1'b0;
			cur_q  <= 12'h000;
		end else if (ce) begin
			if (cmd_go && (op == nbh_pkg::OP_RESET ||
				op == nbh_pkg::OP_RESET2)) begin
				load_q <= 1'b0;
			end else if (cmd_go && st_q == nbh_pkg::ST_IDLE &&
				(op == nbh_pkg::OP_LOAD || op == nbh_pkg::OP_RLOAD)) begin
				load_q <= 1'b1;
				cur_q  <= col_q;
			end else if (cmd_go && st_q == nbh_pkg::ST_IDLE) begin
				load_q <= 1'b0;
			end else if (dat_go) begin
				cur_q <= cur_q + 12'h001;
			end
		end
	end
	// ****************
	// sequencer
	// ****************
	always_ff @(posedge mclk or negedge rs_n) begin
		if (!rs_n) begin
			st_q    <= nbh_pkg::ST_IDLE;
			sec_q   <= 2'h0;
			prot_q  <= 1'b0;
			pfail_q <= 1'b0;
			efail_q <= 1'b0;
		end else if (ce) begin
			case (st_q)
			nbh_pkg::ST_IDLE: begin
				sec_q <= 2'h0;
				if (cmd_go && (op == nbh_pkg::OP_EXEC ||
					op == nbh_pkg::OP_PROTECT)) begin
					prot_q  <= op == nbh_pkg::OP_PROTECT;
					pfail_q <= bad;
					if (!bad) begin
						st_q <= (ecc_en_q && op == nbh_pkg::OP_EXEC) ?
							nbh_pkg::ST_PAR : nbh_pkg::ST_PROG;
					end
				end else if (cmd_go && op == nbh_pkg::OP_ERASE) begin
					efail_q <= bad;
					if (!bad) begin
						st_q <= nbh_pkg::ST_ERASE;
					end
				end
			end
			nbh_pkg::ST_PAR: begin
				sec_q <= sec_q + 2'h1;
				if (sec_q == 2'h3) begin
					st_q <= nbh_pkg::ST_PROG;
				end
			end
			nbh_pkg::ST_PROG, nbh_pkg::ST_ERASE: st_q <= nbh_pkg::ST_WAIT;
			nbh_pkg::ST_WAIT: begin
				if (cmd_go && (op == nbh_pkg::OP_RESET ||
					op == nbh_pkg::OP_RESET2)) begin
					st_q <= nbh_pkg::ST_IDLE;
				end else if (arr_done) begin
					st_q    <= nbh_pkg::ST_IDLE;
					pfail_q <= er_q ? pfail_q : arr_fail;
					efail_q <= efail_q | (arr_fail & er_q);
				end
			end
			default: st_q <= nbh_pkg::ST_IDLE;
			endcase
		end
	end
	// ****************
	// operation kind
	// ****************
	always_ff @(posedge mclk or negedge rs_n) begin
		if (!rs_n) begin
			er_q <= 1'b0;
		end else if (ce && st_q == nbh_pkg::ST_IDLE && cmd_go) begin
			er_q <= op == nbh_pkg::OP_ERASE;
		end
	end
	// ****************
	// array strobes
	// ****************
	always_ff @(posedge mclk or negedge rs_n) begin
		if (!rs_n) begin
			arr_wr      <= 1'b0;
			arr_col     <= 12'h000;
			arr_wdata   <= 8'h00;
			arr_par_wr  <= 1'b0;
			arr_par_sec <= 2'h0;
			arr_par     <= 16'h0000;
			arr_prog    <= 1'b0;
			arr_prot    <= 1'b0;
			arr_erase   <= 1'b0;
			arr_blk     <= 11'h000;
			arr_page    <= 6'h00;
		end else if (ce) begin
			arr_wr     <= dat_go;
			arr_par_wr <= st_q == nbh_pkg::ST_PAR;
			arr_prog   <= st_q == nbh_pkg::ST_PROG;
			arr_prot   <= st_q == nbh_pkg::ST_PROG && prot_q;
			arr_erase  <= st_q == nbh_pkg::ST_ERASE;
			arr_blk    <= blk_q;
			arr_page   <= page_q;
			if (dat_go) begin
				arr_col   <= cur_q;
				arr_wdata <= wdata_q[7:0];
			end
			if (st_q == nbh_pkg::ST_PAR) begin
				arr_par_sec <= sec_q;
				arr_par     <= par;
			end
		end
	end
	// ****************
	// ecc status
	// ****************
	always_ff @(posedge mclk or negedge rs_n) begin
		if (!rs_n) begin
			es_q   <= nbh_pkg::ES_NONE;
			flip_q <= 4'h0;
		end else if (ce && arr_rd_done) begin
			es_q   <= ecc_en_q ? es : nbh_pkg::ES_NONE;
			flip_q <= arr_flips;
		end
	end
	// ****************
	// interrupts
	// ****************
	assign iset = {ce && arr_rd_done && ecc_en_q &&
		es == nbh_pkg::ES_FAIL,
		ce && ((st_q == nbh_pkg::ST_WAIT && arr_done && arr_fail) ||
		(st_q == nbh_pkg::ST_IDLE && cmd_go && bad &&
		(op == nbh_pkg::OP_EXEC || op == nbh_pkg::OP_PROTECT ||
		op == nbh_pkg::OP_ERASE))),
		ce && st_q == nbh_pkg::ST_WAIT && arr_done};
	always_ff @(posedge mclk or negedge rs_n) begin
		if (!rs_n) begin
			ist_q <= 3'h0;
			irq   <= 1'b0;
		end else if (ce) begin
			irq <= |(ist_q & imask_q);
			if (wr_go && waddr_q == nbh_pkg::A_IRQ_STAT) begin
				ist_q <= (ist_q & ~wdata_q[2:0]) | iset;
			end else begin
				ist_q <= ist_q | iset;
			end
		end
	end
	// ****************
	// sub blocks
	// ****************
	nbh_bbt u_bbt (
		.clk      (mclk),
		.rst_n    (rs_n),
		.ce       (ce),
		.mark     (fac_mark),
		.mark_blk (fac_blk),
		.q_blk    (blk_q),
		.q_bad    (bad)
	);
	nbh_ecc u_ecc (
		.clk   (mclk),
		.rst_n (rs_n),
		.ce    (ce),
		.clr   (clr),
		.vld   (dat_go && ecc_en_q),
		.col   (cur_q),
		.data  (wdata_q[7:0]),
		.sel   (sec_q),
		.par   (par),
		.flips (arr_flips),
		.stat  (es)
	);
	// ****************
	// checks
	// ****************
	a_bad_prog_ignored: assert property (@(posedge mclk) disable iff (!rs_n)
		cmd_go && bad && op == nbh_pkg::OP_EXEC &&
		st_q == nbh_pkg::ST_IDLE |=> pfail_q && st_q == nbh_pkg::ST_IDLE
		##1 !arr_prog) else $error("bad block program not ignored");
	a_bad_erase_ignored: assert property (@(posedge mclk) disable iff (!rs_n)
		cmd_go && bad && op == nbh_pkg::OP_ERASE &&
		st_q == nbh_pkg::ST_IDLE |=> efail_q ##1 !arr_erase)
		else $error("bad block erase not ignored");
	a_parity_before_prog: assert property (@(posedge mclk) disable iff (!rs_n)
		$rose(arr_prog) && !arr_prot && ecc_en_q |->
		$past(arr_par_wr) && $past(arr_par_sec) == 2'h3)
		else $error("program without parity");
	a_random_col_jump: assert property (@(posedge mclk) disable iff (!rs_n)
		cmd_go && op == nbh_pkg::OP_RLOAD && st_q == nbh_pkg::ST_IDLE |=>
		load_q && cur_q == $past(col_q))
		else $error("random load column not taken");
	a_ecc_corrects_eight: assert property (@(posedge mclk) disable iff (!rs_n)
		ce && arr_rd_done && ecc_en_q && arr_flips != 4'h0 &&
		arr_flips <= 4'h8 |=> es_q == nbh_pkg::ES_FIXED)
		else $error("correctable count misreported");
endmodule : nbh_top
`default_nettype wire

/* File: rtl/nbh_pkg.sv */
// constants for the nand program and bad-block sequencer
// Summary of operation
// - parity over 512 main plus 16 spare
// - random load jumps column in selected page
// - program or erase to invalid block: ignore, fail
// - ecc corrects up to 8 bits per sector
package nbh_pkg;
	// ****************
	// register offsets
	// ****************
	localparam logic [7:0] A_CTRL     = 8'h00;
	localparam logic [7:0] A_CMD      = 8'h04;
	localparam logic [7:0] A_ROW      = 8'h08;
	localparam logic [7:0] A_COL      = 8'h0c;
	localparam logic [7:0] A_DATA     = 8'h10;
	localparam logic [7:0] A_STATUS   = 8'h14;
	localparam logic [7:0] A_IRQ_STAT = 8'h18;
	localparam logic [7:0] A_IRQ_MASK = 8'h1c;
	// ****************
	// commands
	// ****************
	localparam logic [7:0] OP_LOAD    = 8'h02;
	localparam logic [7:0] OP_RLOAD   = 8'h84;
	localparam logic [7:0] OP_EXEC    = 8'h10;
	localparam logic [7:0] OP_ERASE   = 8'hd8;
	localparam logic [7:0] OP_PROTECT = 8'h2a;
	localparam logic [7:0] OP_RESET   = 8'hff;
	localparam logic [7:0] OP_RESET2  = 8'hfe;
	// ****************
	// page geometry and ecc
	// ****************
	localparam int          NBLK       = 2048;
	localparam int          NSEC       = 4;
	localparam logic [11:0] SPARE_BASE = 12'h800;
	localparam logic [11:0] SPARE_END  = 12'h840;
	localparam logic [15:0] PAR_INIT   = 16'hffff;
	localparam logic [15:0] PAR_POLY   = 16'h1021;
	localparam logic [3:0]  ECC_MAX    = 4'h8;
	localparam logic [1:0]  ES_NONE    = 2'h0;
	localparam logic [1:0]  ES_FIXED   = 2'h1;
	localparam logic [1:0]  ES_FAIL    = 2'h2;
	// ****************
	// status and irq bits
	// ****************
	localparam int B_BUSY  = 0;
	localparam int B_LOAD  = 1;
	localparam int B_PFAIL = 2;
	localparam int B_EFAIL = 3;
	localparam int B_ES    = 4;
	localparam int B_FLIP  = 8;
	localparam int I_DONE  = 0;
	localparam int I_FAIL  = 1;
	localparam int I_UNCOR = 2;
	localparam logic [1:0] RESP_OK  = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
	typedef enum logic [4:0] {
		ST_IDLE  = 5'b00001,
		ST_PAR   = 5'b00010,
		ST_PROG  = 5'b00100,
		ST_ERASE = 5'b01000,
		ST_WAIT  = 5'b10000
	} nbh_state_e;
endpackage : nbh_pkg

/* File: rtl/nbh_bbt.sv */
// invalid block table, one flag per block
`timescale 1ns/1ns
`default_nettype none
module nbh_bbt (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	// marking from the array scan
	input  wire logic        mark,
	input  wire logic [10:0] mark_blk,
	// lookup
	input  wire logic [10:0] q_blk,
	output      logic        q_bad
);
	logic [nbh_pkg::NBLK-1:0] bad_q;
	// ****************
	// flag storage
	// ****************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bad_q <= '0;
		end else if (ce && mark) begin
			bad_q[mark_blk] <= 1'b1;
		end
	end
	assign q_bad = bad_q[q_blk];
endmodule : nbh_bbt
`default_nettype wire

/* File: rtl/nbh_ecc.sv */
// per-sector parity generator and correction classifier
`timescale 1ns/1ns
`default_nettype none
module nbh_ecc (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	// byte stream from program load
	input  wire logic        clr,
	input  wire logic        vld,
	input  wire logic [11:0] col,
	input  wire logic [7:0]  data,
	// parity readout
	input  wire logic [1:0]  sel,
	output      logic [15:0] par,
	// correction classifier
	input  wire logic [3:0]  flips,
	output      logic [1:0]  stat
);
	logic [15:0] par_q [nbh_pkg::NSEC];
	logic [1:0]  sec;
	logic        hit;

	function automatic logic [15:0] crc_byte(input logic [15:0] c,
		input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? nbh_pkg::PAR_POLY
				: 16'h0000);
		end
		return r;
	endfunction : crc_byte

	// ****************
	// sector decode
	// ****************
	// main and spare
	always_comb begin
		hit = 1'b1;
		sec = col[10:9];
		if (col >= nbh_pkg::SPARE_END) begin
			hit = 1'b0;
		end else if (col >= nbh_pkg::SPARE_BASE) begin
			sec = col[5:4];
		end
	end
	// ****************
	// parity accumulators
	// ****************
	generate
		for (genvar s = 0; s < nbh_pkg::NSEC; s++) begin : g_sec
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					par_q[s] <= nbh_pkg::PAR_INIT;
				end else if (ce && clr) begin
					par_q[s] <= nbh_pkg::PAR_INIT;
				end else if (ce && vld && hit && sec == 2'(s)) begin
					par_q[s] <= crc_byte(par_q[s], data);
				end
			end
		end
	endgenerate
	assign par = par_q[sel];
	assign stat = (flips == 4'h0) ? nbh_pkg::ES_NONE :
		(flips <= nbh_pkg::ECC_MAX) ? nbh_pkg::ES_FIXED : nbh_pkg::ES_FAIL;
endmodule : nbh_ecc
`default_nettype wire

/* File: tb/nbh_array_model.sv */
// array-side model: answers program and erase, logs what it sees
`timescale 1ns/1ns
`default_nettype none
module nbh_array_model #(
	parameter int DLY = 5
) (
	// clock
	input  wire logic        mclk,
	// from the sequencer
	input  wire logic        arr_wr,
	input  wire logic [11:0] arr_col,
	input  wire logic        arr_prog,
	input  wire logic        arr_prot,
	input  wire logic        arr_erase,
	input  wire logic        arr_par_wr,
	input  wire logic [1:0]  arr_par_sec,
	// answer
	input  wire logic        fail_cfg,
	output logic             arr_done,
	output logic             arr_fail,
	// log for the bench
	output logic [7:0]       n_prog,
	output logic [7:0]       n_prot,
	output logic [7:0]       n_erase,
	output logic [7:0]       n_par,
	output logic             sec_bad,
	output logic [11:0]      last_col
);
	int         cnt;
	logic       busy;
	logic [1:0] nxt;

	initial begin
		{arr_done, arr_fail, busy, sec_bad, nxt, cnt} = '0;
		{n_prog, n_prot, n_erase, n_par, last_col} = '0;
	end

	always @(posedge mclk) begin
		arr_done <= 1'b0;
		// fail level is only meaningful with done
		arr_fail <= ~arr_fail;
		if (arr_wr)
			last_col <= arr_col;
		if (arr_par_wr) begin
			if (arr_par_sec !== nxt)
				sec_bad <= 1'b1;
			nxt <= nxt + 2'h1;
			n_par <= n_par + 8'h1;
		end
		if (arr_prot)
			n_prot <= n_prot + 8'h1;
		if (arr_prog || arr_erase) begin
			busy <= 1'b1;
			cnt <= DLY;
			n_prog <= n_prog + {7'h0, arr_prog};
			n_erase <= n_erase + {7'h0, arr_erase};
		end else if (busy) begin
			if (cnt == 0) begin
				busy <= 1'b0;
				arr_done <= 1'b1;
				arr_fail <= fail_cfg;
			end else
				cnt <= cnt - 1;
		end
	end
endmodule : nbh_array_model
`default_nettype wire

/* File: tb/nbh_top_tb.sv */
// self-checking bench for the program sequencer
`timescale 1ns/1ns
`default_nettype none
module nbh_top_tb;
	// ****************
	// signals
	// ****************
	logic        mclk, rst_n, ce, irq, fail_cfg, sec_bad;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, n_prog, n_prot, n_erase, n_par;
	logic [31:0] s_axi_wdata, s_axi_rdata, v;
	logic [3:0]  s_axi_wstrb, arr_flips;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic [1:0]  s_axi_bresp, s_axi_rresp, arr_par_sec, rresp, wresp;
	logic        arr_wr, arr_par_wr, arr_prog, arr_prot, arr_erase;
	logic        arr_done, arr_fail, arr_rd_done, fac_mark;
	logic [11:0] arr_col, last_col;
	logic [7:0]  arr_wdata;
	logic [15:0] arr_par;
	logic [10:0] arr_blk, fac_blk;
	logic [5:0]  arr_page;
	int          n_fail, num_checks, cyc;

	nbh_top nbh_top_i (.mclk, .rst_n, .ce, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .arr_wr, .arr_col,
		.arr_wdata, .arr_par_wr, .arr_par_sec, .arr_par, .arr_prog,
		.arr_prot, .arr_erase, .arr_blk, .arr_page, .arr_done, .arr_fail,
		.arr_rd_done, .arr_flips, .fac_mark, .fac_blk, .irq);

	nbh_array_model nbh_array_model_i (.mclk, .arr_wr, .arr_col, .arr_prog,
		.arr_prot, .arr_erase, .arr_par_wr, .arr_par_sec, .fail_cfg,
		.arr_done, .arr_fail, .n_prog, .n_prot, .n_erase, .n_par, .sec_bad,
		.last_col);

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// ****************
	// bus tasks and checks
	// ****************
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ad, dd;
		ad = 1'b0;
		dd = 1'b0;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(ad && dd)) begin
			@(posedge mclk);
			if (!ad && s_axi_awready === 1'b1) begin
				ad = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!dd && s_axi_wready === 1'b1) begin
				dd = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
		wresp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge mclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
		v = s_axi_rdata;
		rresp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd

	task automatic chk(input string nm, input logic [31:0] e, g);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic rchk(input logic [7:0] a, input logic [31:0] m, e,
		input string nm);
		rd(a);
		chk(nm, e, v & m);
	endtask : rchk

	task automatic cmd(input logic [7:0] op);
		wr(nbh_pkg::A_CMD, {24'h0, op});
	endtask : cmd

	task automatic idle;
		do rd(nbh_pkg::A_STATUS);
		while (v[nbh_pkg::B_BUSY] !== 1'b0);
	endtask : idle

	task automatic prog(input logic [31:0] row);
		wr(nbh_pkg::A_ROW, row);
		wr(nbh_pkg::A_COL, 32'h0);
		cmd(nbh_pkg::OP_LOAD);
		wr(nbh_pkg::A_DATA, 32'ha5);
		wr(nbh_pkg::A_DATA, 32'hff);
		cmd(nbh_pkg::OP_EXEC);
		idle();
	endtask : prog

	task automatic rdev(input logic [3:0] f);
		@(posedge mclk);
		arr_flips <= f;
		arr_rd_done <= 1'b1;
		@(posedge mclk);
		arr_rd_done <= 1'b0;
	endtask : rdev

	task automatic conclude;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : conclude

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			conclude();
		end
	end

	// ****************
	// tests
	// ****************
	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, arr_flips, fac_blk} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, arr_rd_done, fac_mark} = '0;
		{rst_n, fail_cfg, n_fail, num_checks, cyc} = '0;
		ce = 1'b1;
		s_axi_wstrb = 4'hf;
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (4) @(posedge mclk);
		wr(8'h01, 32'h0);
		chk("misaligned wr resp", {30'h0, nbh_pkg::RESP_ERR}, {30'h0, wresp});
		rchk(nbh_pkg::A_CTRL, 32'h1, 32'h1, "ecc enable");
		rchk(nbh_pkg::A_STATUS, 32'hfff, 32'h0, "status");
		rd(8'h20);
		chk("unmapped resp", {30'h0, nbh_pkg::RESP_ERR}, {30'h0, rresp});
		wr(nbh_pkg::A_IRQ_MASK, 32'h7);
		$display("test reset done");
		wr(nbh_pkg::A_ROW, 32'h803);
		wr(nbh_pkg::A_COL, 32'h0);
		cmd(nbh_pkg::OP_LOAD);
		wr(nbh_pkg::A_DATA, 32'h3c);
		wr(nbh_pkg::A_COL, 32'h800);
		cmd(nbh_pkg::OP_RLOAD);
		wr(nbh_pkg::A_DATA, 32'h5a);
		@(posedge mclk);
		chk("jump column", 32'h800, {20'h0, last_col});
		chk("last byte", 32'h5a, {24'h0, arr_wdata});
		cmd(nbh_pkg::OP_EXEC);
		idle();
		chk("parity writes", 32'h4, {24'h0, n_par});
		chk("sector order", 32'h0, {31'h0, sec_bad});
		chk("row", 32'h803, {15'h0, arr_page, arr_blk});
		chk("last parity", 32'hffff, {16'h0, arr_par});
		rchk(nbh_pkg::A_STATUS, 32'h4, 32'h0, "pfail");
		rchk(nbh_pkg::A_IRQ_STAT, 32'h1, 32'h1, "done irq");
		chk("irq", 32'h1, {31'h0, irq});
		wr(nbh_pkg::A_IRQ_STAT, 32'h7);
		rchk(nbh_pkg::A_IRQ_STAT, 32'h7, 32'h0, "irq clear");
		chk("irq low", 32'h0, {31'h0, irq});
		$display("test program done");
		@(posedge mclk);
		fac_mark <= 1'b1;
		fac_blk <= 11'h9;
		@(posedge mclk);
		fac_mark <= 1'b0;
		prog(32'h9);
		rchk(nbh_pkg::A_STATUS, 32'h4, 32'h4, "bad pfail");
		cmd(nbh_pkg::OP_ERASE);
		idle();
		rchk(nbh_pkg::A_STATUS, 32'h8, 32'h8, "bad efail");
		chk("no array op", 32'h100, {n_prog, n_erase});
		rchk(nbh_pkg::A_IRQ_STAT, 32'h2, 32'h2, "fail irq");
		wr(nbh_pkg::A_IRQ_STAT, 32'h7);
		$display("test bad block done");
		prog(32'h3);
		rchk(nbh_pkg::A_STATUS, 32'h4, 32'h0, "pfail cleared");
		fail_cfg <= 1'b1;
		cmd(nbh_pkg::OP_PROTECT);
		idle();
		rchk(nbh_pkg::A_STATUS, 32'h4, 32'h4, "protect fail");
		chk("protect pulses", 32'h010308, {n_prot, n_prog, n_par});
		cmd(nbh_pkg::OP_ERASE);
		idle();
		rchk(nbh_pkg::A_STATUS, 32'h8, 32'h8, "erase fail");
		fail_cfg <= 1'b0;
		cmd(nbh_pkg::OP_ERASE);
		idle();
		rchk(nbh_pkg::A_STATUS, 32'h8, 32'h0, "erase pass");
		chk("erase count", 32'h2, {24'h0, n_erase});
		$display("test failures done");
		wr(nbh_pkg::A_CTRL, 32'h0);
		prog(32'h3);
		chk("ecc off parity", 32'h8, {24'h0, n_par});
		wr(nbh_pkg::A_CTRL, 32'h1);
		for (int k = 0; k < 2; k++) begin
			cmd(nbh_pkg::OP_LOAD);
			rchk(nbh_pkg::A_STATUS, 32'h2, 32'h2, "loading");
			cmd(k ? nbh_pkg::OP_RESET2 : nbh_pkg::OP_RESET);
			rchk(nbh_pkg::A_STATUS, 32'h2, 32'h0, "reset load");
		end
		$display("test ecc off done");
		wr(nbh_pkg::A_IRQ_STAT, 32'h7);
		for (int i = 0; i < 4; i++) begin
			logic [3:0] f;
			logic [1:0] es;
			f = (i == 0) ? 4'h0 : (i == 1) ? 4'h3 : (i == 2) ? 4'h8 : 4'hf;
			es = (i == 0) ? nbh_pkg::ES_NONE :
				(i == 3) ? nbh_pkg::ES_FAIL : nbh_pkg::ES_FIXED;
			rdev(f);
			rchk(nbh_pkg::A_STATUS, 32'hf30, {20'h0, f, 2'h0, es, 4'h0},
				"ecc status");
		end
		rchk(nbh_pkg::A_IRQ_STAT, 32'h4, 32'h4, "uncorrectable irq");
		$display("test ecc status done");
		conclude();
	end
endmodule : nbh_top_tb
`default_nettype wire
